// ===== hw/fsm_pkg.sv
package fsm_pkg;

    // ------------------------------------------------------------
    // APB register map
    // ------------------------------------------------------------
    localparam logic [11:0] FSM_CFG_OFFSET      = 12'h000;
    localparam logic [11:0] FSM_ADDR_OFFSET     = 12'h004;
    localparam logic [11:0] FSM_SECTOR_OFFSET   = 12'h008;
    localparam logic [11:0] FSM_CMD_OFFSET      = 12'h00C;
    localparam logic [11:0] FSM_STATUS_OFFSET   = 12'h010;
    localparam logic [11:0] FSM_RDATA_OFFSET    = 12'h014;

    // Configuration register fields
    localparam int FSM_CFG_FREEZE_BIT  = 0;
    localparam int FSM_CFG_TOP_BIT     = 2;
    localparam int FSM_CFG_BLK256_BIT  = 9;
    localparam int FSM_CFG_UNIFORM_BIT = 11;
    localparam logic [31:0] FSM_CFG_RESET = 32'h0000_0000;

    // Command register: [9:8] opcode, [7:0] program data
    localparam logic [1:0] FSM_OP_READ_OTP  = 2'h0;
    localparam logic [1:0] FSM_OP_PROG_OTP  = 2'h1;
    localparam logic [1:0] FSM_OP_READ_ID   = 2'h2;
    localparam logic [1:0] FSM_OP_READ_SFDP = 2'h3;

    // Status fields
    localparam int FSM_ST_PERR_BIT = 0;

    // ------------------------------------------------------------
    // Address space geometry
    // ------------------------------------------------------------
    localparam int FSM_ARRAY_ABITS   = 23;
    localparam int FSM_OTP_BYTES     = 1024;
    localparam int FSM_OTP_ABITS     = 10;
    localparam int FSM_RANDOM_BYTES  = 16;
    localparam logic [9:0] FSM_LOCK_FIRST = 10'h010;
    localparam logic [9:0] FSM_LOCK_LAST  = 10'h013;
    localparam logic [7:0] FSM_ERASED_BYTE = 8'hFF;
    localparam int FSM_ID_BYTES      = 32;
    localparam int FSM_SFDP_BYTES    = 64;
    localparam int FSM_UID_FIRST     = 16;
    localparam int FSM_SFDP_ID_BASE  = 32;

    typedef struct packed {
        logic freeze;
        logic top_select;
        logic block_256k;
        logic uniform;
    } fsm_cfg_type;

    typedef struct packed {
        logic [7:0] index;
        logic [2:0] size_code;
    } fsm_sector_type;

    // size_code encodings
    localparam logic [2:0] FSM_SZ_4K   = 3'h0;
    localparam logic [2:0] FSM_SZ_32K  = 3'h1;
    localparam logic [2:0] FSM_SZ_64K  = 3'h2;
    localparam logic [2:0] FSM_SZ_224K = 3'h3;
    localparam logic [2:0] FSM_SZ_256K = 3'h4;

    typedef enum logic [1:0] {
        FSM_IDLE  = 2'b00,
        FSM_CHECK = 2'b01,
        FSM_WRITE = 2'b11
    } fsm_state_type;

endpackage : fsm_pkg

// ===== hw/fsm_sector_decode.sv
module fsm_sector_decode
    import fsm_pkg::*;
(
    input  wire logic [31:0]    addr,
    input  wire fsm_cfg_type    cfg,
    output fsm_sector_type      sector
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Upper address bits are dropped so 24/32-bit hosts see one map
    wire logic [22:0] a      = addr[FSM_ARRAY_ABITS-1:0];
    wire logic [6:0]  s64    = a[22:16];
    wire logic [4:0]  s256   = a[22:18];
    wire logic [2:0]  s4     = a[14:12];
    wire logic        bot_p  = (a[22:15] == 8'h00);
    wire logic        top_p  = (a[22:15] == 8'hFF);
    wire logic        bot_lg = (a[22:18] == 5'h00);
    wire logic        top_lg = (a[22:18] == 5'h1F);

    always_comb begin
        sector = '{index: 8'h00, size_code: FSM_SZ_64K};
        if (cfg.uniform) begin
            if (cfg.block_256k) begin
                sector = '{index: {3'h0, s256}, size_code: FSM_SZ_256K};
            end else begin
                sector = '{index: {1'b0, s64}, size_code: FSM_SZ_64K};
            end
        end else if (!cfg.top_select) begin
            if (bot_p) begin
                sector = '{index: {5'h00, s4}, size_code: FSM_SZ_4K};
            end else if (cfg.block_256k && bot_lg) begin
                sector = '{index: 8'h08, size_code: FSM_SZ_224K};
            end else if (cfg.block_256k) begin
                sector = '{index: {3'h0, s256} + 8'h08, size_code: FSM_SZ_256K};
            end else if (s64 == 7'h00) begin
                sector = '{index: 8'h08, size_code: FSM_SZ_32K};
            end else begin
                sector = '{index: 8'({1'b0, s64} + 8'h08), size_code: FSM_SZ_64K};
            end
        end else begin
            if (top_p) begin
                sector = '{index: 8'(cfg.block_256k ? 8'h20 : 8'h80) + {5'h00, s4},
                           size_code: FSM_SZ_4K};
            end else if (cfg.block_256k && top_lg) begin
                sector = '{index: 8'h1F, size_code: FSM_SZ_224K};
            end else if (cfg.block_256k) begin
                sector = '{index: {3'h0, s256}, size_code: FSM_SZ_256K};
            end else if (s64 == 7'h7F) begin
                sector = '{index: 8'h7F, size_code: FSM_SZ_32K};
            end else begin
                sector = '{index: {1'b0, s64}, size_code: FSM_SZ_64K};
            end
        end
    end

endmodule // fsm_sector_decode

// ===== hw/fsm_rom_space.sv
module fsm_rom_space
    import fsm_pkg::*;
#(
    parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF, // Arbitrary value
    parameter logic [7:0]  MAKER_ID  = 8'h5A,                   // Arbitrary value
    parameter logic [7:0]  PART_ID   = 8'h3C                    // Arbitrary value
)(
    input  wire logic       sel_sfdp,
    input  wire logic [7:0] addr,
    output logic [7:0]      rdata
);

    // ------------------------------------------------------------
    // Read-only identification and parameter spaces
    // ------------------------------------------------------------
    // No write path exists, so the host can never alter these bytes
    function automatic logic [7:0] id_byte(input logic [4:0] i);
        if (i == 5'h00) begin
            id_byte = MAKER_ID;
        end else if (i == 5'h01) begin
            id_byte = PART_ID;
        end else if (i >= 5'(FSM_UID_FIRST) && i < 5'(FSM_UID_FIRST + 8)) begin
            id_byte = UNIQUE_ID[8*(i - 5'(FSM_UID_FIRST)) +: 8];
        end else begin
            id_byte = 8'h00;
        end
    endfunction

    wire logic [7:0] sfdp_hdr = (addr[5:0] == 6'h00) ? 8'h53 :
                                (addr[5:0] == 6'h01) ? 8'h46 :
                                (addr[5:0] == 6'h02) ? 8'h44 :
                                (addr[5:0] == 6'h03) ? 8'h50 : 8'hFF;
    wire logic       in_id_tbl = (addr >= 8'(FSM_SFDP_ID_BASE)) &&
                                 (addr < 8'(FSM_SFDP_ID_BASE + FSM_ID_BYTES));

    always_comb begin
        if (!sel_sfdp) begin
            rdata = (addr < 8'(FSM_ID_BYTES)) ? id_byte(addr[4:0]) : 8'h00;
        end else if (in_id_tbl) begin
            rdata = id_byte(addr[4:0]);
        end else if (addr < 8'(FSM_SFDP_BYTES)) begin
            rdata = sfdp_hdr;
        end else begin
            rdata = 8'hFF;
        end
    end

endmodule // fsm_rom_space

// ===== hw/fsm_top.sv
// What this block does
// - Uniform 64K map: 128 sectors from zero
// - Bottom hybrid 256K: 8x4K, 224K, 31x256K
// - Top hybrid 256K: 31x256K, 224K, 8x4K
// - Uniform 256K map: 32 logical sectors
// - 4K sectors aligned on low twelve bits
// - 256K sectors aligned on bit eighteen
// - Identification read from separate read-only space
// - Eight-byte unique serial number readable
// - Parameter read space embeds identification table
// - 1024-byte OTP, 32 lockable 32-byte regions
// - Zero into random bytes fails, sets error
// - Ones into random bytes ignored
// - Four lock bytes; zero bit locks region
// - Region n lock is bit n%8, byte n/8
// - Twelve reserved bytes remain host programmable
// - Non-random OTP bytes deliver as FF
// - Freeze bit blocks all OTP programming
// - Uniform-select bit picks hybrid or uniform map
// - Block-size bit picks 256K logical blocks
// - Top-select bit places parameter sectors top
// - Address bits above array width ignored
module fsm_top
    import fsm_pkg::*;
#(
    parameter logic [127:0] RANDOM_NUMBER = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0
)(
    input  wire logic        REF_CLK,
    input  wire logic        RESET_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR
);

    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Registers and storage
    // ------------------------------------------------------------
    logic [31:0]   cfg_q;
    logic [31:0]   addr_q;
    logic          perr_q;
    logic          busy_q;
    logic [7:0]    rdata_q;
    logic [7:0]    pdata_q;
    logic [9:0]    otp_addr_q;
    fsm_state_type state_q;
    fsm_state_type state_d;
    // User OTP bytes; the random bytes live in the parameter instead
    logic [7:0]    otp_mem [FSM_RANDOM_BYTES:FSM_OTP_BYTES-1];

    fsm_cfg_type    cfg;
    fsm_sector_type sector;
    logic [7:0]     rom_rdata;

    assign cfg.freeze     = cfg_q[FSM_CFG_FREEZE_BIT];
    assign cfg.top_select = cfg_q[FSM_CFG_TOP_BIT];
    assign cfg.block_256k = cfg_q[FSM_CFG_BLK256_BIT];
    assign cfg.uniform    = cfg_q[FSM_CFG_UNIFORM_BIT];

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire logic wr_en    = PSEL && PENABLE && PWRITE;
    wire logic rd_sel   = PSEL && PENABLE && !PWRITE;
    wire logic hit_cfg  = (PADDR == FSM_CFG_OFFSET);
    wire logic hit_addr = (PADDR == FSM_ADDR_OFFSET);
    wire logic hit_sec  = (PADDR == FSM_SECTOR_OFFSET);
    wire logic hit_cmd  = (PADDR == FSM_CMD_OFFSET);
    wire logic hit_st   = (PADDR == FSM_STATUS_OFFSET);
    wire logic hit_rd   = (PADDR == FSM_RDATA_OFFSET);
    wire logic mapped   = hit_cfg || hit_addr || hit_sec || hit_cmd || hit_st || hit_rd;
    wire logic [1:0] op = PWDATA[9:8];
    wire logic cmd_go   = wr_en && hit_cmd && PSTRB[1] && PSTRB[0] && !busy_q;
    wire logic st_clr   = wr_en && hit_st && PSTRB[0] && PWDATA[FSM_ST_PERR_BIT];

    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && (!mapped || (wr_en && hit_cmd && busy_q));

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    always_comb begin
        if (!rd_sel) begin
            PRDATA = 32'h0000_0000;
        end else if (hit_cfg) begin
            PRDATA = cfg_q;
        end else if (hit_addr) begin
            PRDATA = addr_q;
        end else if (hit_sec) begin
            PRDATA = {21'h000000, sector.size_code, sector.index};
        end else if (hit_st) begin
            PRDATA = {30'h00000000, busy_q, perr_q};
        end else if (hit_rd) begin
            PRDATA = {24'h000000, rdata_q};
        end else begin
            PRDATA = 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    fsm_sector_decode u_sector (
        .addr   (addr_q),
        .cfg    (cfg),
        .sector (sector)
    );

    fsm_rom_space u_rom (
        .sel_sfdp (op == FSM_OP_READ_SFDP),
        .addr     (addr_q[7:0]),
        .rdata    (rom_rdata)
    );

    // ------------------------------------------------------------
    // OTP protection checks
    // ------------------------------------------------------------
    wire logic [9:0] oa        = addr_q[FSM_OTP_ABITS-1:0];
    wire logic       in_random = (oa < 10'(FSM_RANDOM_BYTES));
    wire logic [4:0] region    = oa[9:5];
    wire logic [7:0] lock_byte = otp_mem[10'(FSM_LOCK_FIRST) + {8'h00, region[4:3]}];
    wire logic       locked    = !lock_byte[region[2:0]];
    wire logic       rnd_zero  = in_random && (pdata_q != 8'hFF);
    wire logic       prog_fail = cfg.freeze || locked || rnd_zero;

    function automatic logic [7:0] otp_read(input logic [9:0] a);
        if (a < 10'(FSM_RANDOM_BYTES)) begin
            otp_read = RANDOM_NUMBER[8*a[3:0] +: 8];
        end else begin
            otp_read = otp_mem[a];
        end
    endfunction

    // ------------------------------------------------------------
    // Program sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            FSM_IDLE: begin
                if (cmd_go && op == FSM_OP_PROG_OTP) begin
                    state_d = FSM_CHECK;
                end
            end
            FSM_CHECK: begin
                state_d = prog_fail ? FSM_IDLE : FSM_WRITE;
            end
            FSM_WRITE: begin
                state_d = FSM_IDLE;
            end
            default: begin
                state_d = FSM_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= FSM_IDLE;
            cfg_q   <= FSM_CFG_RESET;
            addr_q  <= 32'h0000_0000;
            perr_q  <= 1'b0;
            busy_q  <= 1'b0;
            rdata_q <= 8'h00;
            pdata_q <= 8'h00;
        end else begin
            state_q <= state_d;
            busy_q  <= (state_d != FSM_IDLE);
            if (wr_en && hit_cfg) begin
                cfg_q <= merge(cfg_q, PWDATA, PSTRB);
            end
            if (wr_en && hit_addr && !busy_q) begin
                addr_q <= merge(addr_q, PWDATA, PSTRB);
            end
            if (cmd_go) begin
                pdata_q <= PWDATA[7:0];
            end
            if (cmd_go && op == FSM_OP_READ_OTP) begin
                rdata_q <= otp_read(addr_q[9:0]);
            end else if (cmd_go) begin
                rdata_q <= rom_rdata;
            end
            // A new failure wins over a software clear in the same cycle
            if (state_q == FSM_CHECK && prog_fail) begin
                perr_q <= 1'b1;
            end else if (st_clr) begin
                perr_q <= 1'b0;
            end
        end
    end

    // Storage has no reset: it models delivered-state cells, filled below
    always_ff @(posedge REF_CLK) begin
        if (state_q == FSM_WRITE && !in_random) begin
            otp_mem[oa] <= otp_mem[oa] & pdata_q;
        end
    end

    initial begin
        for (int i = FSM_RANDOM_BYTES; i < FSM_OTP_BYTES; i++) begin
            otp_mem[i] = FSM_ERASED_BYTE;
        end
    end

endmodule // fsm_top

// ===== testbench/fsm_top_sva.sv
module fsm_top_sva
    import fsm_pkg::*;
(
    input wire logic        REF_CLK,
    input wire logic        RESET_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    // ------------------------------------------------------------
    // Decode of the observed access
    // ------------------------------------------------------------
    wire logic       acc    = PSEL && PENABLE;
    wire logic       rd_sec = acc && !PWRITE && PADDR == FSM_SECTOR_OFFSET;
    wire logic [2:0] sz     = PRDATA[10:8];
    wire logic [7:0] ix     = PRDATA[7:0];
    property p_sec64; rd_sec && sz == FSM_SZ_64K |-> ix <= 8'h87; endproperty
    a_sec64: assert property (p_sec64) else $error("64K index out of range");
    property p_sec224; rd_sec && sz == FSM_SZ_224K |-> ix == 8'h08 || ix == 8'h1F; endproperty
    a_sec224: assert property (p_sec224) else $error("224K index wrong");
    property p_sec4k;
        rd_sec && sz == FSM_SZ_4K |-> ix <= 8'h07 || ix[7:3] == 5'h04 || ix[7:3] == 5'h10;
    endproperty
    a_sec4k: assert property (p_sec4k) else $error("4K index wrong");
    property p_sec256; rd_sec && sz == FSM_SZ_256K |-> ix <= 8'h27; endproperty
    a_sec256: assert property (p_sec256) else $error("256K index out of range");
    property p_sec32; rd_sec && sz == FSM_SZ_32K |-> ix == 8'h08 || ix == 8'h7F; endproperty
    a_sec32: assert property (p_sec32) else $error("32K index wrong");
    property p_idle; !(acc && !PWRITE) |-> PRDATA == 32'h0000_0000; endproperty
    a_idle: assert property (p_idle) else $error("read data outside read");
    property p_rbyte;
        acc && !PWRITE && PADDR == FSM_RDATA_OFFSET |-> PRDATA[31:8] == 24'h00_0000;
    endproperty
    a_rbyte: assert property (p_rbyte) else $error("read byte upper bits set");
    property p_err; PSLVERR |-> acc; endproperty
    a_err: assert property (p_err) else $error("error outside access");
    property p_unmap; acc && PADDR > FSM_RDATA_OFFSET |-> PSLVERR; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    property p_ready; PSEL && !PENABLE ##1 PSEL && PENABLE |-> PREADY; endproperty
    a_ready: assert property (p_ready) else $error("no ready in access");
endmodule // fsm_top_sva

bind fsm_top fsm_top_sva i_fsm_top_sva (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR));

// ===== testbench/fsm_host_model.sv
module fsm_host_model
    import fsm_pkg::*;
(
    input  wire logic        ref_clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    end
    // Released address and data lines show the inverse so stale values never look valid
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= 4'hF;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
    task automatic apb_wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, a, d, r, e);
    endtask
    task automatic apb_rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        xfer(1'b0, a, 32'h0000_0000, r, e);
    endtask
    // Boot code freezes only after all its programming is done
    task automatic freeze_otp(input logic [31:0] cfg);
        apb_wr(FSM_CFG_OFFSET, cfg | 32'h0000_0001);
    endtask
endmodule // fsm_host_model

// ===== testbench/fsm_top_bench.sv
module fsm_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import fsm_pkg::*;
    localparam logic [127:0] RNUM = 128'h1122_3344_5566_7788_99AA_BBCC_DDEE_FF00;
    localparam logic [63:0]  UID  = 64'h0123_4567_89AB_CDEF; // Arbitrary value
    logic        ref_clk;
    logic        reset_n;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, q;
    logic [3:0]  pstrb;
    logic [15:0] lfsr;
    logic [7:0]  d, d2;
    logic        e;
    int          miscompares, n_tests, cycles;
    fsm_top #(.RANDOM_NUMBER(RNUM)) i_fsm_top (.REF_CLK(ref_clk), .RESET_N(reset_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    fsm_host_model i_fsm_host_model (.ref_clk(ref_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic conclude();
        if (miscompares == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Mode m is {uniform, block_256k, top_select}
    function automatic logic [10:0] sector_exp(input logic [31:0] addr, input logic [2:0] m);
        logic [22:0] a;
        a = addr[22:0];
        if (m[2]) return m[1] ? {FSM_SZ_256K, 8'(a[22:18])} : {FSM_SZ_64K, 8'(a[22:16])};
        if (!m[0]) begin
            if (a < 23'h8000) return {FSM_SZ_4K, 8'(a[14:12])};
            if (!m[1]) return a < 23'h10000 ? {FSM_SZ_32K, 8'h08} : {FSM_SZ_64K, 8'(a[22:16]) + 8'h08};
            return a < 23'h40000 ? {FSM_SZ_224K, 8'h08} : {FSM_SZ_256K, 8'(a[22:18]) + 8'h08};
        end
        if (a >= 23'h7F8000) return {FSM_SZ_4K, 8'(a[14:12]) + (m[1] ? 8'h20 : 8'h80)};
        if (!m[1]) return a >= 23'h7F0000 ? {FSM_SZ_32K, 8'h7F} : {FSM_SZ_64K, 8'(a[22:16])};
        return a >= 23'h7C0000 ? {FSM_SZ_224K, 8'h1F} : {FSM_SZ_256K, 8'(a[22:18])};
    endfunction
    task automatic otp_rd(input logic [9:0] a, input logic [1:0] op, output logic [7:0] v);
        logic [31:0] t;
        i_fsm_host_model.apb_wr(FSM_ADDR_OFFSET, {22'h0, a});
        i_fsm_host_model.apb_wr(FSM_CMD_OFFSET, {22'h0, op, 8'h00});
        i_fsm_host_model.apb_rd(FSM_RDATA_OFFSET, t);
        v = t[7:0];
    endtask
    // Programs one byte, then checks error flag and the stored byte
    task automatic pg_chk(input logic [9:0] a, input logic [7:0] v, input logic xe,
                          input logic [7:0] xb);
        logic [31:0] st;
        logic [7:0]  b;
        i_fsm_host_model.apb_wr(FSM_ADDR_OFFSET, {22'h0, a});
        i_fsm_host_model.apb_wr(FSM_CMD_OFFSET, {22'h0, FSM_OP_PROG_OTP, v});
        st = 32'h0000_0002;
        for (int k = 0; k < 10 && st[1] !== 1'b0; k++) i_fsm_host_model.apb_rd(FSM_STATUS_OFFSET, st);
        check(st[1:0], {1'b0, xe});
        i_fsm_host_model.apb_wr(FSM_STATUS_OFFSET, 32'h0000_0001);
        otp_rd(a, FSM_OP_READ_OTP, b);
        check(b, xb);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    logic [31:0] edges [14] = '{32'h0, 32'h7FFF, 32'h8000, 32'hFFFF, 32'h10000, 32'h3FFFF,
        32'h40000, 32'h7BFFFF, 32'h7C0000, 32'h7EFFFF, 32'h7F0000, 32'h7F7FFF, 32'h7F8000,
        32'h7FFFFF};
    initial begin
        reset_n = 1'b0;
        lfsr = 16'h0026;
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (int m = 0; m < 8; m++) begin
            i_fsm_host_model.apb_wr(FSM_CFG_OFFSET, {20'h0, m[2], 1'b0, m[1], 6'h0, m[0], 2'h0});
            for (int i = 0; i < 18; i++) begin
                lfsr = lfsr_next(lfsr);
                r = i < 14 ? edges[i] | {lfsr[8:0], 23'h0} : {lfsr, lfsr_next(lfsr)};
                i_fsm_host_model.apb_wr(FSM_ADDR_OFFSET, r);
                i_fsm_host_model.apb_rd(FSM_SECTOR_OFFSET, q);
                check(q & 32'h7FF, {21'h0, sector_exp(r, 3'(m))});
            end
        end
        i_fsm_host_model.xfer(1'b0, 12'h020, 32'h0, r, e);
        check(r, 32'h0000_0000);
        check({31'h0, e}, 32'h0000_0001);
        for (int i = 0; i < 8; i++) begin
            otp_rd(10'(16 + i), FSM_OP_READ_ID, d);
            check(d, UID[8 * i +: 8]);
            otp_rd(10'(48 + i), FSM_OP_READ_SFDP, d);
            check(d, UID[8 * i +: 8]);
            otp_rd(10'(i), FSM_OP_READ_OTP, d);
            check(d, RNUM[8 * i +: 8]);
        end
        for (int i = 0; i < 4; i++) begin
            otp_rd(10'(i), FSM_OP_READ_SFDP, d);
            check(d, "SFDP" >> (8 * (3 - i)) & 8'hFF);
        end
        otp_rd(10'h3FF, FSM_OP_READ_OTP, d);
        check(d, FSM_ERASED_BYTE);
        pg_chk(10'h003, 8'hFF, 1'b0, RNUM[31:24]);
        pg_chk(10'h00F, 8'hFE, 1'b1, RNUM[127:120]);
        pg_chk(10'h014, 8'hA5, 1'b0, 8'hA5);
        pg_chk(10'h014, 8'h5A, 1'b0, 8'h00);
        pg_chk(10'h0A0, 8'h3C, 1'b0, 8'h3C);
        pg_chk(10'h010, 8'hDF, 1'b0, 8'hDF);
        pg_chk(10'h0A0, 8'h00, 1'b1, 8'h3C);
        pg_chk(10'h0C0, 8'h12, 1'b0, 8'h12);
        pg_chk(10'h013, 8'h7F, 1'b0, 8'h7F);
        pg_chk(10'h3E5, 8'h00, 1'b1, 8'hFF);
        lfsr = lfsr_next(lfsr);
        d = lfsr[7:0];
        d2 = lfsr[15:8];
        r = {22'h0, 5'(8 + lfsr[3:0]), lfsr[8:4]};
        pg_chk(r[9:0], d, 1'b0, d);
        pg_chk(r[9:0], d2, 1'b0, d & d2);
        i_fsm_host_model.freeze_otp(32'h0000_0000);
        pg_chk(10'h200, 8'h00, 1'b1, 8'hFF);
        conclude();
    end
endmodule // fsm_top_bench
